// File: rtl/dal_slave.sv
`timescale 1ns/1ns
`include "dal_defs.svh"
module dal_slave
	import dal_pkg::*;
#(
	parameter int BIT_CYCLES = `DAL_CLK_HZ / `DAL_BAUD,
	parameter int MS_CYCLES  = `DAL_CLK_HZ / 1000 * `DAL_TICK_MS
)(
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// serial bus
	input  wire logic       bus_rxd,
	output logic            bus_txd,
	output logic            bus_tx_oe,
	// actuation sensors
	input  wire logic [1:0] sensor_in,
	// node status
	output logic            event_latched,
	output logic            job_active,
	output logic            outcome_ack,
	output logic            outcome_mispick
);
	localparam logic [19:0] GAP_LAST = 20'(`DAL_GAP_BITS * BIT_CYCLES - 1);
	localparam logic [16:0] MS_LAST  = 17'(MS_CYCLES - 1);

	dal_byte_t rx_byte;
	logic      rx_err, tx_busy, go_reg, go_next;
	logic [7:0] tx_data_reg, tx_data_next;
	dal_wr_t   wr;

	dal_uart #(.BIT_CYCLES(BIT_CYCLES)) u_uart (
		.core_clk (core_clk),
		.rst      (rst),
		.rxd_pin  (bus_rxd),
		.txd      (bus_txd),
		.tx_oe    (bus_tx_oe),
		.tx_start (go_reg),
		.tx_data  (tx_data_reg),
		.tx_busy  (tx_busy),
		.rx_byte  (rx_byte),
		.rx_err   (rx_err)
	);

	function automatic logic [15:0] crc_step(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++)
			r = r[0] ? ((r >> 1) ^ `DAL_CRC_POLY) : (r >> 1);
		return r;
	endfunction

	// ----------------------------------------------------------------
	// frame capture: silence of 3.5 characters ends a frame
	// ----------------------------------------------------------------
	logic [7:0]  rxb_reg [0:7];
	logic [7:0]  rxb_next [0:7];
	logic [3:0]  rx_cnt_reg, rx_cnt_next;
	logic        rx_bad_reg, rx_bad_next, inf_reg, inf_next;
	logic [15:0] crc_rx_reg, crc_rx_next;
	logic [19:0] gap_reg, gap_next;
	logic        frame_done;

	assign frame_done = inf_reg && !rx_byte.valid && !rx_err &&
		gap_reg == GAP_LAST;

	always_comb begin
		for (int i = 0; i < 8; i++)
			rxb_next[i] = rxb_reg[i];
		rx_cnt_next = rx_cnt_reg;
		rx_bad_next = rx_bad_reg | rx_err;
		crc_rx_next = crc_rx_reg;
		gap_next    = gap_reg;
		inf_next    = inf_reg;
		if (rx_byte.valid || rx_err) begin
			gap_next = 20'h00000;
			inf_next = 1'b1;
			if (rx_byte.valid) begin
				if (rx_cnt_reg < 4'h8)
					rxb_next[rx_cnt_reg[2:0]] = rx_byte.data;
				if (rx_cnt_reg != 4'hF)
					rx_cnt_next = rx_cnt_reg + 4'h1;
				crc_rx_next = crc_step(crc_rx_reg, rx_byte.data);
			end
		end else if (frame_done) begin
			inf_next    = 1'b0;
			gap_next    = 20'h00000;
			rx_cnt_next = 4'h0;
			rx_bad_next = 1'b0;
			crc_rx_next = `DAL_CRC_INIT;
		end else if (inf_reg) begin
			gap_next = gap_reg + 20'h00001;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < 8; i++)
				rxb_reg[i] <= 8'h00;
			rx_cnt_reg <= 4'h0;
			rx_bad_reg <= 1'b0;
			crc_rx_reg <= `DAL_CRC_INIT;
			gap_reg    <= 20'h00000;
			inf_reg    <= 1'b0;
		end else begin
			for (int i = 0; i < 8; i++)
				rxb_reg[i] <= rxb_next[i];
			rx_cnt_reg <= rx_cnt_next;
			rx_bad_reg <= rx_bad_next;
			crc_rx_reg <= crc_rx_next;
			gap_reg    <= gap_next;
			inf_reg    <= inf_next;
		end
	end

	// ----------------------------------------------------------------
	// register file and event latch
	// ----------------------------------------------------------------
	logic [15:0] unit_bus_address, unit_next;
	logic [15:0] actuation_output_state, state_next;
	logic [15:0] job_state_control, job_next;
	logic [15:0] shared_group_address, group_next;
	logic [15:0] event_latch_timeout, tmo_next;
	logic [15:0] outcome_reg, outcome_next, tmr_reg, tmr_next;
	logic [16:0] ms_reg, ms_next;
	logic [1:0]  sens_prev_reg, press;
	logic        latched_next, active_next, ack_next, mis_next;
	logic [2:0]  sens_sync [0:1];
	logic        sens_lvl [0:1];
	wire logic [1:0] sens_bits;

	for (genvar s = 0; s < 2; s++) begin : g_sens
		logic lvl_next;
		always_comb
			lvl_next = (sens_sync[s][1] == sens_sync[s][2]) ?
				sens_sync[s][2] : sens_lvl[s];
		always_ff @(posedge core_clk) begin
			if (rst) begin
				sens_sync[s] <= 3'h0;
				sens_lvl[s]  <= 1'b0;
			end else begin
				sens_sync[s] <= {sens_sync[s][1:0], sensor_in[s]};
				sens_lvl[s]  <= lvl_next;
			end
		end
		assign sens_bits[s] = sens_lvl[s];
	end

	always_comb begin
		unit_next  = unit_bus_address;
		state_next = actuation_output_state;
		job_next   = job_state_control;
		group_next = shared_group_address;
		tmo_next   = event_latch_timeout;
		press      = sens_bits & ~sens_prev_reg;
		ms_next    = (ms_reg == MS_LAST) ? 17'h00000 : ms_reg + 17'h00001;
		if (wr.en) begin
			case (wr.addr)
				`DAL_REG_UNIT:  unit_next  = wr.data;
				`DAL_REG_STATE: state_next = wr.data;
				`DAL_REG_JOB:   job_next   = wr.data;
				`DAL_REG_GROUP: group_next = wr.data;
				`DAL_REG_TMO:   tmo_next   = wr.data;
				default: ;
			endcase
			if (wr.addr >= `DAL_REG_JOB && wr.addr <= `DAL_REG_JOB_LAST)
				state_next = 16'h0000;
		end
		// zero timeout disables expiry
		if (actuation_output_state != 16'h0000 &&
			event_latch_timeout != 16'h0000 &&
			tmr_reg >= event_latch_timeout)
			state_next = 16'h0000;
		// a press in the clearing cycle still latches
		if (press != 2'b00 && state_next == 16'h0000) begin
			state_next   = {14'h0000, press};
			outcome_next = (job_state_control == `DAL_JOB_ACTIVE) ?
				`DAL_OUT_ACK : `DAL_OUT_MISPICK;
		end else if (state_next == 16'h0000) begin
			outcome_next = 16'h0000;
		end else begin
			outcome_next = outcome_reg;
		end
		if (state_next == 16'h0000 || actuation_output_state == 16'h0000 ||
			(press != 2'b00 && state_next != actuation_output_state))
			tmr_next = 16'h0000;
		else if (ms_reg == MS_LAST && tmr_reg != 16'hFFFF)
			tmr_next = tmr_reg + 16'h0001;
		else
			tmr_next = tmr_reg;
		latched_next = state_next != 16'h0000;
		active_next  = job_next == `DAL_JOB_ACTIVE;
		ack_next     = outcome_next == `DAL_OUT_ACK;
		mis_next     = outcome_next == `DAL_OUT_MISPICK;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			unit_bus_address       <= `DAL_RST_UNIT;
			actuation_output_state <= 16'h0000;
			job_state_control      <= `DAL_RST_JOB;
			shared_group_address   <= `DAL_RST_GROUP;
			event_latch_timeout    <= `DAL_RST_TMO;
			outcome_reg            <= 16'h0000;
			tmr_reg                <= 16'h0000;
			ms_reg                 <= 17'h00000;
			sens_prev_reg          <= 2'b00;
			event_latched          <= 1'b0;
			job_active             <= 1'b0;
			outcome_ack            <= 1'b0;
			outcome_mispick        <= 1'b0;
		end else begin
			unit_bus_address       <= unit_next;
			actuation_output_state <= state_next;
			job_state_control      <= job_next;
			shared_group_address   <= group_next;
			event_latch_timeout    <= tmo_next;
			outcome_reg            <= outcome_next;
			tmr_reg                <= tmr_next;
			ms_reg                 <= ms_next;
			sens_prev_reg          <= sens_bits;
			event_latched          <= latched_next;
			job_active             <= active_next;
			outcome_ack            <= ack_next;
			outcome_mispick        <= mis_next;
		end
	end

	// ----------------------------------------------------------------
	// request interpreter and reply builder
	// ----------------------------------------------------------------
	dal_st_t     st_reg, st_next;
	logic [7:0]  fc_reg, fc_next, exc_reg, exc_next;
	logic [15:0] ra_reg, ra_next, qv_reg, qv_next, crc_reg, crc_next;
	logic        grp_reg, grp_next, bc_reg, bc_next, len_reg, len_next;
	logic [3:0]  idx_reg, idx_next;
	logic [4:0]  n_reg, n_next, k_reg, k_next;
	logic [7:0]  txb_reg [0:20];
	logic [7:0]  txb_next [0:20];
	logic [15:0] cur, rd_val;
	logic        rd_hit, own, grp;

	always_comb begin
		cur = ra_reg + {12'h000, idx_reg};
		rd_hit = 1'b1;
		case (cur)
			`DAL_REG_UNIT:    rd_val = unit_bus_address;
			`DAL_REG_STATE:   rd_val = actuation_output_state;
			`DAL_REG_OUTCOME: rd_val = outcome_reg;
			`DAL_REG_JOB:     rd_val = job_state_control;
			`DAL_REG_GROUP:   rd_val = shared_group_address;
			`DAL_REG_TMO:     rd_val = event_latch_timeout;
			default: begin
				rd_val = 16'h0000;
				rd_hit = cur > `DAL_REG_JOB && cur <= `DAL_REG_JOB_LAST;
			end
		endcase
		if (grp_reg && (cur < `DAL_REG_UNIT || cur > `DAL_REG_OUTCOME))
			rd_hit = 1'b0;
	end

	always_comb begin
		st_next = st_reg;
		fc_next = fc_reg;
		exc_next = exc_reg;
		ra_next = ra_reg;
		qv_next = qv_reg;
		crc_next = crc_reg;
		grp_next = grp_reg;
		bc_next = bc_reg;
		len_next = len_reg;
		idx_next = idx_reg;
		n_next = n_reg;
		k_next = k_reg;
		go_next = 1'b0;
		tx_data_next = tx_data_reg;
		wr = '0;
		for (int i = 0; i < 21; i++)
			txb_next[i] = txb_reg[i];
		own = rxb_reg[0] == unit_bus_address[7:0];
		grp = rxb_reg[0] == shared_group_address[7:0] &&
			actuation_output_state != 16'h0000;
		case (st_reg)
			ST_IDLE: if (frame_done && !rx_bad_reg && crc_rx_reg == 16'h0000 &&
				rx_cnt_reg >= 4'h4 && (own || grp ||
				rxb_reg[0] == `DAL_BCAST)) begin
				fc_next  = rxb_reg[1];
				ra_next  = {rxb_reg[2], rxb_reg[3]};
				qv_next  = {rxb_reg[4], rxb_reg[5]};
				grp_next = grp && !own;
				bc_next  = rxb_reg[0] == `DAL_BCAST;
				len_next = rx_cnt_reg == 4'h8;
				txb_next[0] = rxb_reg[0];
				txb_next[1] = rxb_reg[1];
				st_next = ST_DECODE;
			end
			ST_DECODE: begin
				idx_next = 4'h0;
				st_next  = ST_EXC;
				if (fc_reg != `DAL_FC_READ && fc_reg != `DAL_FC_WRITE)
					exc_next = `DAL_EXC_FUNC;
				else if (!len_reg || (fc_reg == `DAL_FC_READ &&
					(qv_reg == 16'h0000 || qv_reg > `DAL_MAX_READ)))
					exc_next = `DAL_EXC_VAL;
				else if (fc_reg == `DAL_FC_WRITE)
					st_next = ST_WRITE;
				else if (!bc_reg)
					st_next = ST_READ;
				else
					st_next = ST_IDLE;
			end
			ST_READ: if (!rd_hit) begin
				exc_next = `DAL_EXC_ADDR;
				st_next  = ST_EXC;
			end else begin
				txb_next[5'(3 + 2 * idx_reg)] = rd_val[15:8];
				txb_next[5'(4 + 2 * idx_reg)] = rd_val[7:0];
				idx_next = idx_reg + 4'h1;
				if ({12'h000, idx_next} == qv_reg) begin
					txb_next[2] = {qv_reg[6:0], 1'b0};
					n_next = 5'(3 + 2 * qv_reg[3:0]);
					k_next = 5'h00;
					crc_next = `DAL_CRC_INIT;
					st_next  = ST_CRC;
				end
			end
			ST_WRITE: if (!rd_hit || ra_reg == `DAL_REG_OUTCOME) begin
				exc_next = `DAL_EXC_ADDR;
				st_next  = ST_EXC;
			end else begin
				wr = '{en: 1'b1, addr: ra_reg, data: qv_reg};
				txb_next[2] = ra_reg[15:8];
				txb_next[3] = ra_reg[7:0];
				txb_next[4] = qv_reg[15:8];
				txb_next[5] = qv_reg[7:0];
				n_next   = 5'h06;
				k_next   = 5'h00;
				crc_next = `DAL_CRC_INIT;
				st_next  = bc_reg ? ST_IDLE : ST_CRC;
			end
			ST_EXC: begin
				txb_next[1] = fc_reg | `DAL_FC_EXC;
				txb_next[2] = exc_reg;
				n_next   = 5'h03;
				k_next   = 5'h00;
				crc_next = `DAL_CRC_INIT;
				// broadcasts never get a reply, not even an error
				st_next  = bc_reg ? ST_IDLE : ST_CRC;
			end
			ST_CRC: if (k_reg < n_reg) begin
				crc_next = crc_step(crc_reg, txb_reg[k_reg]);
				k_next   = k_reg + 5'h01;
			end else begin
				txb_next[n_reg] = crc_reg[7:0];
				txb_next[5'(n_reg + 5'h01)] = crc_reg[15:8];
				n_next  = n_reg + 5'h02;
				k_next  = 5'h00;
				st_next = ST_SEND;
			end
			ST_SEND: if (!tx_busy && !go_reg) begin
				if (k_reg == n_reg) begin
					st_next = ST_IDLE;
				end else begin
					go_next      = 1'b1;
					tx_data_next = txb_reg[k_reg];
					k_next       = k_reg + 5'h01;
				end
			end
			default: st_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_reg  <= ST_IDLE;
			fc_reg  <= 8'h00;
			exc_reg <= 8'h00;
			ra_reg  <= 16'h0000;
			qv_reg  <= 16'h0000;
			crc_reg <= `DAL_CRC_INIT;
			grp_reg <= 1'b0;
			bc_reg  <= 1'b0;
			len_reg <= 1'b0;
			idx_reg <= 4'h0;
			n_reg   <= 5'h00;
			k_reg   <= 5'h00;
			go_reg  <= 1'b0;
			tx_data_reg <= 8'h00;
			for (int i = 0; i < 21; i++)
				txb_reg[i] <= 8'h00;
		end else begin
			st_reg  <= st_next;
			fc_reg  <= fc_next;
			exc_reg <= exc_next;
			ra_reg  <= ra_next;
			qv_reg  <= qv_next;
			crc_reg <= crc_next;
			grp_reg <= grp_next;
			bc_reg  <= bc_next;
			len_reg <= len_next;
			idx_reg <= idx_next;
			n_reg   <= n_next;
			k_reg   <= k_next;
			go_reg  <= go_next;
			tx_data_reg <= tx_data_next;
			for (int i = 0; i < 21; i++)
				txb_reg[i] <= txb_next[i];
		end
	end

endmodule

// File: rtl/dal_defs.svh
`ifndef DAL_DEFS_SVH
`define DAL_DEFS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DAL_CLK_HZ       100000000
`define DAL_BAUD         19200
`define DAL_TICK_MS      1
`define DAL_GAP_BITS     39
`define DAL_TX_BITS      4'd11

// ----------------------------------------------------------------
// frame limits and protocol codes
// ----------------------------------------------------------------
`define DAL_MAX_READ     16'h0008
`define DAL_FC_READ      8'h03
`define DAL_FC_WRITE     8'h06
`define DAL_FC_EXC       8'h80
`define DAL_EXC_FUNC     8'h01
`define DAL_EXC_ADDR     8'h02
`define DAL_EXC_VAL      8'h03
`define DAL_BCAST        8'h00
`define DAL_CRC_INIT     16'hFFFF
`define DAL_CRC_POLY     16'hA001

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define DAL_REG_UNIT     16'h1F04
`define DAL_REG_STATE    16'h1F05
`define DAL_REG_OUTCOME  16'h1F06
`define DAL_REG_JOB      16'h21FC
`define DAL_REG_JOB_LAST 16'h2230
`define DAL_REG_GROUP    16'h226A
`define DAL_REG_TMO      16'h226C

// ----------------------------------------------------------------
// reset values and field codes
// ----------------------------------------------------------------
`define DAL_RST_UNIT     16'h0001
`define DAL_RST_GROUP    16'h00C3
`define DAL_RST_TMO      16'h03E8
`define DAL_RST_JOB      16'h0000
`define DAL_JOB_ACTIVE   16'h0001
`define DAL_OUT_ACK      16'h0001
`define DAL_OUT_MISPICK  16'h0002

`endif

// File: rtl/dal_pkg.sv
package dal_pkg;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} dal_byte_t;

	typedef struct packed {
		logic        en;
		logic [15:0] addr;
		logic [15:0] data;
	} dal_wr_t;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b10,
		RX_STOP  = 2'b11
	} dal_rx_st_t;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_DECODE = 3'b001,
		ST_READ   = 3'b010,
		ST_WRITE  = 3'b011,
		ST_EXC    = 3'b100,
		ST_CRC    = 3'b101,
		ST_SEND   = 3'b110
	} dal_st_t;

endpackage

// File: rtl/dal_uart.sv
`timescale 1ns/1ns
`include "dal_defs.svh"
module dal_uart
	import dal_pkg::*;
#(
	parameter int BIT_CYCLES = `DAL_CLK_HZ / `DAL_BAUD
)(
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// serial line
	input  wire logic       rxd_pin,
	output logic            txd,
	output logic            tx_oe,
	// byte side
	input  wire logic       tx_start,
	input  wire logic [7:0] tx_data,
	output logic            tx_busy,
	output dal_byte_t       rx_byte,
	output logic            rx_err
);
	localparam logic [15:0] BIT_LAST  = 16'(BIT_CYCLES - 1);
	localparam logic [15:0] HALF_LAST = 16'(BIT_CYCLES / 2 - 1);

	// ----------------------------------------------------------------
	// receiver
	// ----------------------------------------------------------------
	logic [2:0]  sync_reg;
	logic        level_reg, level_next;
	dal_rx_st_t  rx_st_reg, rx_st_next;
	logic [15:0] rx_cnt_reg, rx_cnt_next;
	logic [2:0]  rx_bit_reg, rx_bit_next;
	logic [7:0]  rx_sh_reg, rx_sh_next;
	dal_byte_t   rx_byte_next;
	logic        rx_err_next;

	always_comb begin
		// a change counts only once the last two stages agree
		level_next = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : level_reg;
		rx_st_next   = rx_st_reg;
		rx_cnt_next  = rx_cnt_reg;
		rx_bit_next  = rx_bit_reg;
		rx_sh_next   = rx_sh_reg;
		rx_byte_next = '0;
		rx_err_next  = 1'b0;
		if (rx_st_reg != RX_IDLE)
			rx_cnt_next = rx_cnt_reg - 16'h0001;
		case (rx_st_reg)
			RX_IDLE: if (!level_reg) begin
				rx_st_next  = RX_START;
				rx_cnt_next = HALF_LAST;
			end
			RX_START: if (rx_cnt_reg == 16'h0000) begin
				rx_cnt_next = BIT_LAST;
				rx_bit_next = 3'h0;
				// a glitch shorter than half a bit is not a start
				rx_st_next  = level_reg ? RX_IDLE : RX_DATA;
			end
			RX_DATA: if (rx_cnt_reg == 16'h0000) begin
				rx_sh_next  = {level_reg, rx_sh_reg[7:1]};
				rx_bit_next = rx_bit_reg + 3'h1;
				rx_cnt_next = BIT_LAST;
				if (rx_bit_reg == 3'h7)
					rx_st_next = RX_STOP;
			end
			RX_STOP: if (rx_cnt_reg == 16'h0000) begin
				rx_st_next = RX_IDLE;
				if (level_reg)
					rx_byte_next = {1'b1, rx_sh_reg};
				else
					rx_err_next = 1'b1;
			end
			default: rx_st_next = RX_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			sync_reg   <= 3'h7;
			level_reg  <= 1'b1;
			rx_st_reg  <= RX_IDLE;
			rx_cnt_reg <= 16'h0000;
			rx_bit_reg <= 3'h0;
			rx_sh_reg  <= 8'h00;
			rx_byte    <= '0;
			rx_err     <= 1'b0;
		end else begin
			sync_reg   <= {sync_reg[1:0], rxd_pin};
			level_reg  <= level_next;
			rx_st_reg  <= rx_st_next;
			rx_cnt_reg <= rx_cnt_next;
			rx_bit_reg <= rx_bit_next;
			rx_sh_reg  <= rx_sh_next;
			rx_byte    <= rx_byte_next;
			rx_err     <= rx_err_next;
		end
	end

	// ----------------------------------------------------------------
	// transmitter: start, 8 data, two stop bits
	// ----------------------------------------------------------------
	logic [10:0] tx_sh_reg, tx_sh_next;
	logic [3:0]  tx_bit_reg, tx_bit_next;
	logic [15:0] tx_cnt_reg, tx_cnt_next;
	logic        tx_busy_next, txd_next, tx_oe_next;

	always_comb begin
		tx_sh_next   = tx_sh_reg;
		tx_bit_next  = tx_bit_reg;
		tx_cnt_next  = tx_cnt_reg;
		tx_busy_next = tx_busy;
		if (!tx_busy) begin
			if (tx_start) begin
				tx_sh_next   = {2'b11, tx_data, 1'b0};
				tx_bit_next  = `DAL_TX_BITS;
				tx_cnt_next  = BIT_LAST;
				tx_busy_next = 1'b1;
			end
		end else if (tx_cnt_reg == 16'h0000) begin
			tx_sh_next  = {1'b1, tx_sh_reg[10:1]};
			tx_bit_next = tx_bit_reg - 4'h1;
			tx_cnt_next = BIT_LAST;
			if (tx_bit_reg == 4'h1)
				tx_busy_next = 1'b0;
		end else begin
			tx_cnt_next = tx_cnt_reg - 16'h0001;
		end
		txd_next   = tx_busy_next ? tx_sh_next[0] : 1'b1;
		tx_oe_next = tx_busy_next;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			tx_sh_reg  <= 11'h7FF;
			tx_bit_reg <= 4'h0;
			tx_cnt_reg <= 16'h0000;
			tx_busy    <= 1'b0;
			txd        <= 1'b1;
			tx_oe      <= 1'b0;
		end else begin
			tx_sh_reg  <= tx_sh_next;
			tx_bit_reg <= tx_bit_next;
			tx_cnt_reg <= tx_cnt_next;
			tx_busy    <= tx_busy_next;
			txd        <= txd_next;
			tx_oe      <= tx_oe_next;
		end
	end

endmodule

// File: dv/dal_slave_checker.sv
`timescale 1ns/1ns
module dal_slave_checker #(
	parameter int BIT_CYCLES = 16
)(
	// clock
	input wire logic       core_clk,
	input wire logic       rst,
	// pins
	input wire logic       bus_rxd,
	input wire logic       bus_txd,
	input wire logic       bus_tx_oe,
	input wire logic [1:0] sensor_in,
	input wire logic       event_latched,
	input wire logic       job_active,
	input wire logic       outcome_ack,
	input wire logic       outcome_mispick
);
	logic [19:0] idle_reg, idle_next;
	logic [3:0]  age_reg, age_next;
	logic        gap;
	// one bit time short of the frame gap, for sync delay
	assign gap = idle_reg >= 20'(38 * BIT_CYCLES);
	always_comb begin
		idle_next = idle_reg;
		age_next = age_reg;
		if (!bus_rxd)
			idle_next = 20'h00000;
		else if (idle_reg != 20'hFFFFF)
			idle_next = idle_reg + 20'h00001;
		if (|sensor_in)
			age_next = 4'h0;
		else if (age_reg != 4'hF)
			age_next = age_reg + 4'h1;
	end
	always_ff @(posedge core_clk) begin
		idle_reg <= rst ? 20'h00000 : idle_next;
		age_reg <= rst ? 4'hF : age_next;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	AST_IDLE_HIGH: assert property (!bus_tx_oe |-> bus_txd)
		else $error("txd low with driver off");
	AST_TALK_GAP: assert property ($rose(bus_tx_oe) |-> gap)
		else $error("reply before frame gap");
	AST_START_BIT: assert property (
		$rose(bus_tx_oe) |-> ##[0:3] !bus_txd)
		else $error("no start bit");
	AST_EVT_CAUSE: assert property (
		$rose(event_latched) |-> age_reg <= 4'h7 || gap)
		else $error("latch without cause");
	AST_OUT_EXCL: assert property (
		!(outcome_ack && outcome_mispick))
		else $error("both outcomes");
	AST_ACK_JOB: assert property (
		$rose(outcome_ack) |-> $past(job_active))
		else $error("ack while waiting");
	AST_MIS_WAIT: assert property (
		$rose(outcome_mispick) |-> !$past(job_active))
		else $error("mispick while active");
	AST_JOB_CLR: assert property (
		$rose(job_active) |-> !event_latched)
		else $error("job write kept latch");
	AST_JOB_FRAME: assert property (
		$changed(job_active) |-> gap && !bus_tx_oe)
		else $error("job changed off frame");
endmodule

bind dal_slave dal_slave_checker #(.BIT_CYCLES(BIT_CYCLES)) i_chk (
	.core_clk       (core_clk),
	.rst            (rst),
	.bus_rxd        (bus_rxd),
	.bus_txd        (bus_txd),
	.bus_tx_oe      (bus_tx_oe),
	.sensor_in      (sensor_in),
	.event_latched  (event_latched),
	.job_active     (job_active),
	.outcome_ack    (outcome_ack),
	.outcome_mispick(outcome_mispick)
);

// File: dv/dal_master.sv
`timescale 1ns/1ns
module dal_master #(
	parameter int BIT_CYCLES = 16
)(
	// clock
	input wire logic core_clk,
	// bus
	input wire logic bus_txd,
	input wire logic bus_tx_oe,
	output logic     bus_rxd
);
	logic line;
	// a released bus is biased to the idle mark
	assign line = bus_tx_oe ? bus_txd : 1'b1;
	initial bus_rxd = 1'b1;
	function automatic logic [15:0] crc(input logic [7:0] b[16], int n);
		logic [15:0] c = 16'hFFFF;
		for (int i = 0; i < n; i++) begin
			c = c ^ {8'h00, b[i]};
			for (int k = 0; k < 8; k++)
				c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
		end
		return c;
	endfunction
	task automatic send(input logic [9:0] f);
		for (int i = 0; i < 10; i++) begin
			@(negedge core_clk);
			bus_rxd = f[i];
			repeat (BIT_CYCLES - 1) @(negedge core_clk);
		end
	endtask
	// one request then its reply; silence is a normal outcome
	task automatic txn(input logic [7:0] h[6], output int n,
		output logic [7:0] r[16], output logic ok);
		logic [7:0]  f[16];
		logic [15:0] c;
		int          w;
		f = '{default: 8'h00};
		r = '{default: 8'h00};
		for (int i = 0; i < 6; i++)
			f[i] = h[i];
		c = crc(f, 6);
		f[6] = c[7:0];
		f[7] = c[15:8];
		for (int i = 0; i < 8; i++)
			send({1'b1, f[i], 1'b0});
		n = 0;
		w = 1000;
		while (w > 0) begin
			@(negedge core_clk);
			w--;
			if (!line && n < 16) begin
				repeat (BIT_CYCLES / 2) @(negedge core_clk);
				for (int k = 0; k < 8; k++) begin
					repeat (BIT_CYCLES) @(negedge core_clk);
					r[n][k] = line;
				end
				repeat (BIT_CYCLES) @(negedge core_clk);
				n++;
				w = 4 * BIT_CYCLES;
			end
		end
		c = crc(r, n - 2);
		ok = n > 2 && r[n-2] == c[7:0] && r[n-1] == c[15:8];
	endtask
endmodule

// File: dv/dal_slave_test.sv
`timescale 1ns/1ns
module dal_slave_test;
	logic       core_clk = 1'b0;
	logic       rst = 1'b1;
	logic       rxd, txd, oe, ev, job, ack, mis;
	logic [1:0] sensor_in = 2'h0;
	int         mismatches = 0;
	int         check_count = 0;
	always #5 core_clk = ~core_clk;
	dal_slave #(.BIT_CYCLES(8), .MS_CYCLES(50)) i_dut (
		.core_clk(core_clk), .rst(rst), .bus_rxd(rxd),
		.bus_txd(txd), .bus_tx_oe(oe), .sensor_in(sensor_in),
		.event_latched(ev), .job_active(job),
		.outcome_ack(ack), .outcome_mispick(mis));
	dal_master #(.BIT_CYCLES(8)) i_mst (.core_clk(core_clk),
		.bus_txd(txd), .bus_tx_oe(oe), .bus_rxd(rxd));
	task automatic chk(string nm, logic [15:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// en is the reply length expected, zero for silence
	task automatic op(logic [7:0] id, fc, logic [15:0] ra, v,
		int en, logic [15:0] ew);
		logic [7:0] r[16];
		int         n;
		logic       ok;
		i_mst.txn('{id, fc, ra[15:8], ra[7:0], v[15:8], v[7:0]},
			n, r, ok);
		chk("length", 16'(n), 16'(en));
		if (en > 0) begin
			chk("crc", {15'h0000, ok}, 16'h0001);
			chk("id", {8'h00, r[0]}, {8'h00, id});
			chk("word", en == 5 ? {8'h00, r[2]} :
				en == 8 ? {r[4], r[5]} : {r[3], r[4]}, ew);
		end
	endtask
	task automatic rd(logic [7:0] id, logic [15:0] ra, ew);
		op(id, 8'h03, ra, 16'h0001, 7, ew);
	endtask
	task automatic wr(logic [7:0] id, logic [15:0] ra, v);
		op(id, 8'h06, ra, v, 8, v);
	endtask
	task automatic press(logic [1:0] m);
		@(negedge core_clk);
		sensor_in = m;
		repeat (6) @(negedge core_clk);
		sensor_in = 2'h0;
		repeat (6) @(negedge core_clk);
	endtask
	initial begin
		repeat (100000) @(posedge core_clk);
		mismatches++;
		summarize();
	end
	initial begin
		repeat (2) @(negedge core_clk);
		rst = 1'b0;
		rd(8'h01, 16'h1F04, 16'h0001);
		rd(8'h01, 16'h1F05, 16'h0000);
		rd(8'h01, 16'h21FC, 16'h0000);
		rd(8'h01, 16'h226A, 16'h00C3);
		rd(8'h01, 16'h226C, 16'h03E8);
		op(8'h01, 8'h04, 16'h1F04, 16'h0001, 5, 16'h0001);
		op(8'h01, 8'h03, 16'h1F04, 16'h0000, 5, 16'h0003);
		$display("test reset_map done");
		op(8'hC3, 8'h03, 16'h1F04, 16'h0001, 0, 16'h0000);
		press(2'h2);
		chk("latched", {15'h0000, ev}, 16'h0001);
		chk("mispick", {15'h0000, mis}, 16'h0001);
		chk("ack", {15'h0000, ack}, 16'h0000);
		op(8'hC3, 8'h03, 16'h1F04, 16'h0002, 9, 16'h0001);
		rd(8'hC3, 16'h1F05, 16'h0002);
		rd(8'hC3, 16'h1F06, 16'h0002);
		op(8'hC3, 8'h03, 16'h21FC, 16'h0001, 5, 16'h0002);
		rd(8'h01, 16'h1F05, 16'h0002);
		wr(8'h01, 16'h1F05, 16'h0000);
		op(8'hC3, 8'h03, 16'h1F04, 16'h0001, 0, 16'h0000);
		$display("test common_poll done");
		wr(8'h01, 16'h21FC, 16'h0001);
		chk("job", {15'h0000, job}, 16'h0001);
		press(2'h1);
		rd(8'h01, 16'h1F06, 16'h0001);
		chk("ack", {15'h0000, ack}, 16'h0001);
		chk("mispick", {15'h0000, mis}, 16'h0000);
		wr(8'h01, 16'h2230, 16'h0005);
		chk("latched", {15'h0000, ev}, 16'h0000);
		$display("test job_clear done");
		wr(8'h01, 16'h226A, 16'h0022);
		press(2'h3);
		rd(8'h22, 16'h1F05, 16'h0003);
		wr(8'h01, 16'h226C, 16'h0003);
		repeat (300) @(negedge core_clk);
		chk("latched", {15'h0000, ev}, 16'h0000);
		press(2'h1);
		repeat (70) @(negedge core_clk);
		chk("latched", {15'h0000, ev}, 16'h0001);
		repeat (230) @(negedge core_clk);
		chk("latched", {15'h0000, ev}, 16'h0000);
		$display("test timeout done");
		// broadcast writes act but never answer
		op(8'h00, 8'h06, 16'h21FC, 16'h0000, 0, 16'h0000);
		chk("job", {15'h0000, job}, 16'h0000);
		@(negedge core_clk);
		rst = 1'b1;
		repeat (2) @(negedge core_clk);
		rst = 1'b0;
		rd(8'h01, 16'h226A, 16'h00C3);
		rd(8'h01, 16'h226C, 16'h03E8);
		$display("test bcast_reset done");
		summarize();
	end
endmodule
